// file: rx_filter_cfg.svh
// Function
// RL1: Raw capture stores one whole byte unchanged.
// RL2: Decimal conversion writes binary value after digits.
// RL3: Conversions discard bytes outside their symbol set.
// RL4: Accumulate until non-digit or digit count reached.
// RL5: Keep low 8 or 16 bits.
// RL6: Two-digit decimal variant stops after two digits.
// RL7: String collection stores bytes until count written.
// RL8: Optional end byte or length ends collection.
// RL9: End byte itself is never stored.
// RL10: Early end zero-fills remaining string locations.
// RL11: Literal wait matches up to six bytes, blocking.
// RL12: Exact byte match; differing input restarts search.
// RL13: Array match uses zero terminator or length.
// RL14: Action list items run strictly in order.
// RL15: Skip discards exactly the given byte count.
// RL16: Sender makes ones count even with parity.
// RL17: Receiver checks even parity over seven data bits.
// RL18: Parity error aborts list when target enabled.
// RL19: Without timeout, wait forever for list completion.
// RL20: Millisecond timeout aborts when no data arrives.
// RL21: Any received byte restarts the timeout.
// RL22: Parity and timeout report through separate flags.
// RL23: Setting 24972 means 2400 baud, 7E, inverted.
// RL24: Low 13 bits give bit period minus 20us.
// RL25: Bit 13 selects 8N or 7E framing.
// RL26: Bit 14 selects inverted line polarity.
// RL27: Start, LSB-first data, parity, stop; centre sampled.
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH

// Timing.
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define US_NS 1000
`define PERIOD_OFS_US 20
`define CNT_W 17

// Register byte offsets.
`define REG_CTRL 12'h000
`define REG_LINE 12'h004
`define REG_TMO 12'h008
`define REG_STATUS 12'h00c
`define LIST_BASE 12'h100
`define DATA_BASE 12'h200

// Field positions.
`define CTRL_START 0
`define CTRL_PERR_EN 1
`define CTRL_TMO_EN 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_PERR 2
`define STAT_TMO 3
`define STAT_BYTE_LO 8

// Reset values: 9600 baud, 8N, inverted.
`define LINE_RST 16'h4054
`define TMO_RST 16'h0000

// Number bases and symbols.
`define BASE_BIN 2'h0
`define BASE_DEC 2'h1
`define BASE_HEX 2'h2
`define CH_0 8'h30
`define CH_1 8'h31
`define CH_9 8'h39
`define CH_A 8'h41
`define CH_F 8'h46
`define CH_PLUS 8'h2b
`define CH_MINUS 8'h2d
`define HEX_A_VAL 4'ha
`define WAIT_MAX 8'h06
`define WAIT_STEP 2'h3
`define STALE_CYC 2'h2

`endif

// file: rx_filter_pkg.sv
package rx_filter_pkg;

	typedef struct packed {
		logic unused;
		logic invert;
		logic seven_even;
		logic [12:0] period;
	} line_set_s;

	typedef enum logic [3:0] {
		OP_END = 4'h0,
		OP_RAW = 4'h1,
		OP_NUM = 4'h2,
		OP_STR = 4'h3,
		OP_WAIT = 4'h4,
		OP_WAITSTR = 4'h5,
		OP_SKIP = 4'h6
	} action_op_e;

	// Option bit: signed for OP_NUM, end byte enabled for OP_STR.
	typedef struct packed {
		logic [7:0] arg_c;
		logic [7:0] arg_b;
		logic [7:0] arg_a;
		logic word_dest;
		logic opt;
		logic [1:0] base;
		action_op_e op;
	} action_s;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic valid;
		logic perr;
		logic [7:0] data;
	} rx_byte_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_LOAD = 3'b011,
		ST_RUN = 3'b010,
		ST_WRHI = 3'b110,
		ST_FILL = 3'b111,
		ST_DONE = 3'b100
	} eng_state_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b011,
		RX_PAR = 3'b010,
		RX_STOP = 3'b110
	} rx_state_e;

	typedef enum logic [1:0] {
		RG_REG = 2'h0,
		RG_LIST = 2'h1,
		RG_DATA = 2'h2,
		RG_NONE = 2'h3
	} region_e;

endpackage : rx_filter_pkg

// file: rx_filter_mem.sv
`timescale 1ns/100ps
module rx_filter_mem #(
	parameter int W = 8,
	parameter int AW = 6
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Write port.
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [W-1:0] wdata_in,
	// Registered read ports.
	input wire logic [AW-1:0] raddr_a_in,
	output logic [W-1:0] rdata_a_out,
	input wire logic [AW-1:0] raddr_b_in,
	output logic [W-1:0] rdata_b_out
);

	logic [W-1:0] mem_r [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_r[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_a_out <= '0;
			rdata_b_out <= '0;
		end else begin
			rdata_a_out <= mem_r[raddr_a_in];
			rdata_b_out <= mem_r[raddr_b_in];
		end
	end

endmodule : rx_filter_mem

// file: rx_filter.sv
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "rx_filter_cfg.svh"
module rx_filter import rx_filter_pkg::*; #(
	parameter int CYC_PER_MS = `MS_NS / `CLK_PERIOD_NS,
	parameter int LIST_AW = 4,
	parameter int DATA_AW = 6
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// APB slave.
	input wire apb_req_s apb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Serial line.
	input wire logic rxd_in
);

	localparam int CYC_PER_US = `US_NS / `CLK_PERIOD_NS;

	line_set_s line_r;
	logic [15:0] tmo_r;
	logic perr_en_r, tmo_en_r;
	logic busy_r, done_r, perr_r, tmo_flag_r;
	logic [7:0] last_byte_r;

	function automatic region_e region_of(input logic [11:0] a);
		if (a[11:4] == 8'h00) begin
			return RG_REG;
		end else if ((a & ~12'((1 << (LIST_AW + 2)) - 1)) == `LIST_BASE) begin
			return RG_LIST;
		end else if ((a & ~12'((1 << (DATA_AW + 2)) - 1)) == `DATA_BASE) begin
			return RG_DATA;
		end
		return RG_NONE;
	endfunction : region_of

	function automatic logic [4:0] digit_of(input logic [7:0] b, input logic [1:0] base);
		logic [4:0] r;
		r = 5'h00;
		case (base)
			`BASE_BIN: if (b == `CH_0 || b == `CH_1) r = {1'b1, 4'(b - `CH_0)};
			`BASE_DEC: if (b >= `CH_0 && b <= `CH_9) r = {1'b1, 4'(b - `CH_0)};
			`BASE_HEX: begin
				if (b >= `CH_0 && b <= `CH_9) begin
					r = {1'b1, 4'(b - `CH_0)};
				end else if (b >= `CH_A && b <= `CH_F) begin
					r = {1'b1, 4'(4'(b - `CH_A) + `HEX_A_VAL)};
				end
			end
			default: r = 5'h00;
		endcase
		return r;
	endfunction : digit_of

	// APB decode; writes land only at the completing edge.
	region_e rgn;
	logic apb_fire, apb_wr, start_req;
	logic [31:0] rd_mux;
	logic rd_err;
	logic [31:0] act_rd_a, act_rd_b;
	logic [7:0] dm_rd_a, dm_rd_b;

	assign rgn = region_of(apb_in.paddr);
	assign apb_fire = apb_in.psel & apb_in.penable & pready_out;
	assign apb_wr = apb_fire & apb_in.pwrite;
	assign start_req = apb_wr && rgn == RG_REG && apb_in.paddr == `REG_CTRL &&
		apb_in.pwdata[`CTRL_START] && !busy_r;

	always_comb begin
		rd_mux = 32'h0;
		rd_err = 1'b0;
		case (rgn)
			RG_REG: begin
				case (apb_in.paddr)
					`REG_CTRL: begin
						rd_mux[`CTRL_PERR_EN] = perr_en_r;
						rd_mux[`CTRL_TMO_EN] = tmo_en_r;
					end
					`REG_LINE: rd_mux[15:0] = line_r;
					`REG_TMO: rd_mux[15:0] = tmo_r;
					`REG_STATUS: begin
						rd_mux[`STAT_BUSY] = busy_r;
						rd_mux[`STAT_DONE] = done_r;
						rd_mux[`STAT_PERR] = perr_r;
						rd_mux[`STAT_TMO] = tmo_flag_r;
						rd_mux[`STAT_BYTE_LO +: 8] = last_byte_r;
					end
					default: rd_err = 1'b1;
				endcase
			end
			RG_LIST: rd_mux = act_rd_b;
			RG_DATA: rd_mux[7:0] = dm_rd_b;
			default: rd_err = 1'b1;
		endcase
	end

	// Answer on the second access cycle so the memory read ports have settled.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
		end else if (apb_in.psel && apb_in.penable && !pready_out) begin
			pready_out <= 1'b1;
			pslverr_out <= rd_err;
			// Read data stands until the next read answer, so a write leaves it alone.
			prdata_out <= apb_in.pwrite ? prdata_out : rd_mux;
		end else begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_r <= `LINE_RST;
			tmo_r <= `TMO_RST;
			perr_en_r <= 1'b0;
			tmo_en_r <= 1'b0;
		end else if (apb_wr && rgn == RG_REG && !busy_r) begin
			case (apb_in.paddr)
				`REG_CTRL: begin
					perr_en_r <= apb_in.pwdata[`CTRL_PERR_EN];
					tmo_en_r <= apb_in.pwdata[`CTRL_TMO_EN];
				end
				`REG_LINE: line_r <= apb_in.pwdata[15:0]; // RL23
				`REG_TMO: tmo_r <= apb_in.pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Receiver. Period is the field plus a fixed offset, in microseconds.
	logic [`CNT_W-1:0] bit_cyc, rx_cnt_r;
	rx_state_e rx_st_r;
	logic [7:0] sh_r;
	logic [2:0] nbits_r;
	logic par_r, lvl;
	rx_byte_s rx_r;

	assign bit_cyc = `CNT_W'((`CNT_W'(line_r.period) + `CNT_W'(`PERIOD_OFS_US)) *
		`CNT_W'(CYC_PER_US)); // RL24
	assign lvl = rxd_in ^ line_r.invert; // RL26

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_st_r <= RX_IDLE;
			rx_cnt_r <= '0;
			sh_r <= 8'h00;
			nbits_r <= 3'h0;
			par_r <= 1'b0;
			rx_r <= '0;
			last_byte_r <= 8'h00;
		end else begin
			rx_r.valid <= 1'b0;
			if (rx_st_r != RX_IDLE && rx_cnt_r != '0) begin
				rx_cnt_r <= rx_cnt_r - 1'b1;
			end else begin
				case (rx_st_r) // RL27
					RX_IDLE: if (!lvl) begin
						rx_cnt_r <= bit_cyc >> 1;
						rx_st_r <= RX_START;
					end
					RX_START: begin
						rx_cnt_r <= bit_cyc - 1'b1;
						nbits_r <= 3'h0;
						rx_st_r <= lvl ? RX_IDLE : RX_DATA;
					end
					RX_DATA: begin
						sh_r <= {lvl, sh_r[7:1]};
						nbits_r <= nbits_r + 1'b1;
						rx_cnt_r <= bit_cyc - 1'b1;
						if (nbits_r == {2'b11, ~line_r.seven_even}) begin // RL25
							rx_st_r <= line_r.seven_even ? RX_PAR : RX_STOP;
						end
					end
					RX_PAR: begin
						par_r <= lvl;
						rx_cnt_r <= bit_cyc - 1'b1;
						rx_st_r <= RX_STOP;
					end
					RX_STOP: begin
						rx_r.valid <= 1'b1;
						rx_r.data <= line_r.seven_even ? {1'b0, sh_r[7:1]} : sh_r;
						rx_r.perr <= line_r.seven_even & (^{sh_r[7:1], par_r}); // RL17
						last_byte_r <= line_r.seven_even ? {1'b0, sh_r[7:1]} : sh_r;
						rx_st_r <= RX_IDLE;
					end
					default: rx_st_r <= RX_IDLE;
				endcase
			end
		end
	end

	// No-data timeout in milliseconds.
	logic [23:0] pre_r;
	logic [15:0] ms_r;
	logic tmo_fire;

	assign tmo_fire = busy_r && tmo_en_r && ms_r == tmo_r; // RL20

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre_r <= 24'h0;
			ms_r <= 16'h0;
		end else if (!busy_r || !tmo_en_r || rx_r.valid) begin // RL21
			pre_r <= 24'h0;
			ms_r <= 16'h0;
		end else if (pre_r == 24'(CYC_PER_MS - 1)) begin
			pre_r <= 24'h0;
			ms_r <= ms_r + 16'h1;
		end else begin
			pre_r <= pre_r + 24'h1;
		end
	end

	// Action list sequencer.
	eng_state_e st_r;
	action_s instr_r;
	logic [LIST_AW-1:0] pc_r, adv_pc;
	logic [1:0] ofs_r, stale_r;
	logic [63:0] lit_r;
	logic [7:0] idx_r, cnt_r, hi_r, wait_len, lit_byte;
	logic [15:0] acc_r, acc_step, num_out, radix;
	logic started_r, neg_r, adv_wrap;
	eng_state_e adv_st;
	logic [4:0] dig;
	logic num_take, num_sign, num_done;
	logic eng_we_r;
	logic [DATA_AW-1:0] eng_waddr_r;
	logic [7:0] eng_wdata_r;

	always_comb begin
		{adv_wrap, adv_pc} = (LIST_AW + 1)'({1'b0, pc_r} +
			((instr_r.op == OP_WAIT) ? (LIST_AW + 1)'(`WAIT_STEP) : (LIST_AW + 1)'(1)));
		adv_st = adv_wrap ? ST_DONE : ST_FETCH; // RL14
		dig = digit_of(rx_r.data, instr_r.base); // RL3
		case (instr_r.base)
			`BASE_BIN: radix = 16'h0002;
			`BASE_DEC: radix = 16'h000a;
			default: radix = 16'h0010;
		endcase
		acc_step = 16'(acc_r * radix + 16'(dig[3:0])); // RL5
		num_take = rx_r.valid && dig[4];
		num_sign = rx_r.valid && !dig[4] && !started_r && instr_r.opt &&
			(rx_r.data == `CH_PLUS || rx_r.data == `CH_MINUS);
		num_done = (num_take && instr_r.arg_b != 8'h00 &&
			8'(cnt_r + 8'h1) == instr_r.arg_b) || // RL6
			(rx_r.valid && !dig[4] && !num_sign && started_r); // RL4
		num_out = neg_r ? 16'(16'h0 - (num_take ? acc_step : acc_r)) :
			(num_take ? acc_step : acc_r);
		wait_len = (instr_r.arg_b > `WAIT_MAX) ? `WAIT_MAX : instr_r.arg_b; // RL11
		lit_byte = lit_r[{idx_r[2:0], 3'b000} +: 8];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= ST_IDLE;
			instr_r <= '0;
			pc_r <= '0;
			ofs_r <= 2'h0;
			lit_r <= 64'h0;
			idx_r <= 8'h00;
			cnt_r <= 8'h00;
			hi_r <= 8'h00;
			acc_r <= 16'h0;
			started_r <= 1'b0;
			neg_r <= 1'b0;
			stale_r <= 2'h0;
			eng_we_r <= 1'b0;
			eng_waddr_r <= '0;
			eng_wdata_r <= 8'h00;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			perr_r <= 1'b0;
			tmo_flag_r <= 1'b0;
		end else begin
			eng_we_r <= 1'b0;
			if (stale_r != 2'h0) begin
				stale_r <= stale_r - 2'h1;
			end
			if (busy_r && rx_r.valid && rx_r.perr && perr_en_r) begin // RL18
				perr_r <= 1'b1; // RL22
				busy_r <= 1'b0;
				st_r <= ST_IDLE;
			end else if (tmo_fire) begin
				tmo_flag_r <= 1'b1; // RL22
				busy_r <= 1'b0;
				st_r <= ST_IDLE;
			end else begin
				case (st_r)
					ST_IDLE: if (start_req) begin
						{busy_r, done_r, perr_r, tmo_flag_r} <= 4'b1000;
						pc_r <= '0;
						ofs_r <= 2'h0;
						st_r <= ST_FETCH;
					end
					ST_FETCH: st_r <= ST_LOAD;
					ST_LOAD: begin
						ofs_r <= 2'h0;
						st_r <= ST_RUN;
						if (ofs_r == 2'h0) begin
							instr_r <= act_rd_a;
							{idx_r, cnt_r, acc_r, started_r, neg_r} <= '0;
							stale_r <= `STALE_CYC;
							if (act_rd_a[3:0] == OP_END) begin
								st_r <= ST_DONE;
							end else if (act_rd_a[3:0] == OP_WAIT) begin
								ofs_r <= 2'h1;
								st_r <= ST_FETCH;
							end
						end else if (ofs_r == 2'h1) begin
							lit_r[31:0] <= act_rd_a;
							ofs_r <= 2'h2;
							st_r <= ST_FETCH;
						end else begin
							lit_r[63:32] <= act_rd_a;
						end
					end
					// Only one step per received byte; the byte time far exceeds the
					// few cycles of fetch, so nothing is lost between actions.
					ST_RUN: case (instr_r.op)
						OP_RAW: if (rx_r.valid) begin // RL1
							eng_we_r <= 1'b1;
							eng_waddr_r <= DATA_AW'(instr_r.arg_a);
							eng_wdata_r <= rx_r.data;
							pc_r <= adv_pc;
							st_r <= adv_st;
						end
						OP_NUM: begin
							if (num_take) begin
								acc_r <= acc_step;
								cnt_r <= cnt_r + 8'h1;
								started_r <= 1'b1;
							end
							if (num_sign) begin
								started_r <= 1'b1;
								neg_r <= rx_r.data == `CH_MINUS;
							end
							if (num_done) begin // RL2
								eng_we_r <= 1'b1;
								eng_waddr_r <= DATA_AW'(instr_r.arg_a);
								eng_wdata_r <= num_out[7:0];
								hi_r <= num_out[15:8];
								if (instr_r.word_dest) begin
									st_r <= ST_WRHI;
								end else begin
									pc_r <= adv_pc;
									st_r <= adv_st;
								end
							end
						end
						OP_STR: if (instr_r.arg_b == 8'h00) begin
							pc_r <= adv_pc;
							st_r <= adv_st;
						end else if (rx_r.valid) begin
							if (instr_r.opt && rx_r.data == instr_r.arg_c) begin // RL8 RL9
								st_r <= ST_FILL;
							end else begin
								eng_we_r <= 1'b1; // RL7
								eng_waddr_r <= DATA_AW'(instr_r.arg_a + idx_r);
								eng_wdata_r <= rx_r.data;
								idx_r <= idx_r + 8'h1;
								if (8'(idx_r + 8'h1) == instr_r.arg_b) begin
									pc_r <= adv_pc;
									st_r <= adv_st;
								end
							end
						end
						OP_WAIT: if (wait_len == 8'h00) begin
							pc_r <= adv_pc;
							st_r <= adv_st;
						end else if (rx_r.valid) begin
							if (rx_r.data == lit_byte) begin // RL12
								idx_r <= idx_r + 8'h1;
								if (8'(idx_r + 8'h1) == wait_len) begin
									pc_r <= adv_pc;
									st_r <= adv_st;
								end
							end else begin
								idx_r <= (rx_r.data == lit_r[7:0]) ? 8'h01 : 8'h00;
							end
						end
						OP_WAITSTR: if (stale_r == 2'h0) begin // RL13
							if ((instr_r.arg_b == 8'h00 && dm_rd_a == 8'h00) ||
								(instr_r.arg_b != 8'h00 && idx_r == instr_r.arg_b)) begin
								pc_r <= adv_pc;
								st_r <= adv_st;
							end else if (rx_r.valid) begin
								idx_r <= (rx_r.data == dm_rd_a) ? 8'(idx_r + 8'h1) : 8'h00;
								stale_r <= `STALE_CYC;
							end
						end
						OP_SKIP: if (cnt_r == instr_r.arg_b) begin // RL15
							pc_r <= adv_pc;
							st_r <= adv_st;
						end else if (rx_r.valid) begin
							cnt_r <= cnt_r + 8'h1;
						end
						default: st_r <= ST_DONE;
					endcase
					ST_WRHI: begin
						eng_we_r <= 1'b1;
						eng_waddr_r <= DATA_AW'(instr_r.arg_a + 8'h1);
						eng_wdata_r <= hi_r;
						pc_r <= adv_pc;
						st_r <= adv_st;
					end
					ST_FILL: if (idx_r >= instr_r.arg_b) begin
						pc_r <= adv_pc;
						st_r <= adv_st;
					end else begin
						eng_we_r <= 1'b1; // RL10
						eng_waddr_r <= DATA_AW'(instr_r.arg_a + idx_r);
						eng_wdata_r <= 8'h00;
						idx_r <= idx_r + 8'h1;
					end
					ST_DONE: begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
						st_r <= ST_IDLE;
					end
					default: st_r <= ST_IDLE;
				endcase
			end
			// With the timeout disabled only a finished list, a parity error abort or reset leaves busy.
			// RL19
		end
	end

	rx_filter_mem #(.W(32), .AW(LIST_AW)) list_mem (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.we_in(apb_wr && rgn == RG_LIST && !busy_r),
		.waddr_in(apb_in.paddr[LIST_AW+1:2]),
		.wdata_in(apb_in.pwdata),
		.raddr_a_in(LIST_AW'(pc_r + LIST_AW'(ofs_r))),
		.rdata_a_out(act_rd_a),
		.raddr_b_in(apb_in.paddr[LIST_AW+1:2]),
		.rdata_b_out(act_rd_b)
	);

	// Software writes to the array are dropped while a list runs.
	rx_filter_mem #(.W(8), .AW(DATA_AW)) data_mem (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.we_in(eng_we_r || (apb_wr && rgn == RG_DATA && !busy_r)),
		.waddr_in(eng_we_r ? eng_waddr_r : apb_in.paddr[DATA_AW+1:2]),
		.wdata_in(eng_we_r ? eng_wdata_r : apb_in.pwdata[7:0]),
		.raddr_a_in(DATA_AW'(instr_r.arg_a + idx_r)),
		.rdata_a_out(dm_rd_a),
		.raddr_b_in(apb_in.paddr[DATA_AW+1:2]),
		.rdata_b_out(dm_rd_b)
	);

endmodule : rx_filter

// file: rx_filter_properties.sv
`timescale 1ns/100ps
`include "rx_filter_cfg.svh"
module rx_filter_properties import rx_filter_pkg::*; (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Bus and line.
	input wire apb_req_s apb_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic rxd_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic rd_ok;
	assign rd_ok = pready_out && !apb_in.pwrite;
	sequence s_setup;
		apb_in.psel && !apb_in.penable;
	endsequence
	sequence s_access;
		apb_in.psel && apb_in.penable;
	endsequence
	a_one_wait: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
		else $error("answer not in second access cycle");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (pready_out |-> s_access)
		else $error("ready outside an access");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_upper_err: assert property (pready_out && apb_in.paddr >= 12'h300 |-> pslverr_out)
		else $error("no error above the data array");
	a_hole_err: assert property (pready_out && apb_in.paddr inside {[12'h010:12'h0fc]}
		|-> pslverr_out) else $error("no error in register hole");
	a_mapped_ok: assert property (pready_out && apb_in.paddr < 12'h010 |-> !pslverr_out)
		else $error("error on a mapped register");
	a_err_zero: assert property (rd_ok && pslverr_out |-> prdata_out == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!rd_ok |-> $stable(prdata_out))
		else $error("read data moved without a read");
	a_busy_clean: assert property (rd_ok && apb_in.paddr == `REG_STATUS && prdata_out[0]
		|-> prdata_out[3:1] == 3'h0) else $error("busy with an outcome flag");
endmodule : rx_filter_properties

bind rx_filter rx_filter_properties rx_filter_properties_i (.clk_in(clk_in), .rst_in(rst_in),
	.apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .rxd_in(rxd_in));

// file: serial_sender.sv
`timescale 1ns/100ps
module serial_sender #(
	parameter int BIT_CYC = 200
) (
	// Clock.
	input wire logic clk_in,
	// Line setting.
	input wire logic invert_in,
	// Serial line.
	output logic rxd_out
);
	logic active_r = 1'b0;
	logic level_r = 1'b0;
	// Between frames the line rests at mark, so no stray start is seen while invert_in matches the receiver's invert setting.
	assign rxd_out = active_r ? level_r : ~invert_in;
	task automatic send(input logic [7:0] d, input logic seven, input logic bad_par);
		logic [9:0] bits;
		bits = seven ? {1'b1, (^d[6:0]) ^ bad_par, d[6:0], 1'b0} : {1'b1, d, 1'b0};
		@(posedge clk_in);
		active_r <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			level_r <= bits[i] ^ invert_in;
			repeat (BIT_CYC) @(posedge clk_in);
		end
		active_r <= 1'b0;
	endtask : send
endmodule : serial_sender

// file: tb_rx_filter.sv
`timescale 1ns/100ps
`include "rx_filter_cfg.svh"
module tb_rx_filter import rx_filter_pkg::*; ;
	localparam int BIT_CYC = 200;
	logic clk_in;
	logic rst_in;
	logic inv;
	logic rxd;
	logic pready;
	logic pslverr;
	logic er;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [31:0] seed;
	logic [31:0] lst [10];
	logic [7:0] rnd;
	logic [15:0] v;
	apb_req_s apb;
	int n_errors = 0;
	int num_checks = 0;

	rx_filter #(.CYC_PER_MS(20), .LIST_AW(4), .DATA_AW(6)) rx_filter_i (.clk_in(clk_in),
		.rst_in(rst_in), .apb_in(apb), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rxd_in(rxd));
	serial_sender #(.BIT_CYC(BIT_CYC)) serial_sender_i (.clk_in(clk_in), .invert_in(inv),
		.rxd_out(rxd));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction : lfsr

	function automatic logic [31:0] act(input action_op_e op, input logic [1:0] base,
		input logic opt, input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		return {c, b, a, 1'b0, opt, base, op};
	endfunction : act

	// Digits only; the value is kept as a 32-bit int so that truncation is seen by the caller.
	function automatic int numval(input string s, input int base);
		int n;
		n = 0;
		foreach (s[i]) begin
			n = n * base + ((s[i] >= "A") ? s[i] - "A" + 10 : s[i] - "0");
		end
		return n;
	endfunction : numval

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_in);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge clk_in);
		apb.penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_errors++;
		rd = prdata;
		er = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask : bus

	task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp, input logic ex_err);
		bus(1'b0, addr, 32'h0);
		check(rd, exp);
		check(er, ex_err);
	endtask : rdchk

	task automatic dchk(input int i, input logic [7:0] e);
		rdchk(`DATA_BASE + 12'(4 * i), {24'h0, e}, 1'b0);
	endtask : dchk

	task automatic send_str(input string s);
		foreach (s[i]) begin
			seed = lfsr(seed);
			repeat (seed[5:0]) @(posedge clk_in);
			serial_sender_i.send(s[i], 1'b0, 1'b0);
		end
	endtask : send_str

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, `REG_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 3000);
		if (n >= 3000) n_errors++;
	endtask : wait_idle

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	initial begin
		repeat (90000) @(posedge clk_in);
		n_errors++;
		complete_run();
	end

	initial begin
		apb = '0;
		inv = 1'b1;
		rst_in = 1'b1;
		seed = 32'he4fa2b4f;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rdchk(`REG_LINE, 32'h4054, 1'b0);
		rdchk(`REG_TMO, 32'h0, 1'b0);
		rdchk(`REG_CTRL, 32'h0, 1'b0);
		rdchk(`REG_STATUS, 32'h0, 1'b0);
		rdchk(12'h010, 32'h0, 1'b1);
		rdchk(12'h300, 32'h0, 1'b1);
		lst = '{act(OP_RAW, 2'h0, 1'b0, 8'h0, 8'h0, 8'h0),
			act(OP_NUM, `BASE_DEC, 1'b0, 8'h1, 8'h0, 8'h0) | 32'h80,
			act(OP_STR, 2'h0, 1'b1, 8'h3, 8'h4, "!"),
			act(OP_WAIT, 2'h0, 1'b0, 8'h0, 8'h2, 8'h0), 32'h00006b6f, 32'h0,
			act(OP_SKIP, 2'h0, 1'b0, 8'h0, 8'h2, 8'h0),
			act(OP_NUM, `BASE_DEC, 1'b0, 8'h7, 8'h2, 8'h0),
			act(OP_NUM, `BASE_HEX, 1'b0, 8'h8, 8'h0, 8'h0), 32'h0};
		bus(1'b1, `REG_LINE, 32'h4000);
		foreach (lst[i]) bus(1'b1, `LIST_BASE + 12'(4 * i), lst[i]);
		for (int i = 3; i < 7; i++) bus(1'b1, `DATA_BASE + 12'(4 * i), 32'haa);
		bus(1'b1, `REG_CTRL, 32'h1);
		seed = lfsr(seed);
		rnd = seed[7:0];
		serial_sender_i.send(rnd, 1'b0, 1'b0);
		send_str("x70000 hi!oXokzz345F ");
		wait_idle();
		rdchk(`REG_STATUS, 32'h00002002, 1'b0);
		dchk(0, rnd);
		v = 16'(numval("70000", 10));
		dchk(1, v[7:0]);
		dchk(2, v[15:8]);
		dchk(3, "h");
		dchk(4, "i");
		dchk(5, 8'h0);
		dchk(6, 8'h0);
		dchk(7, 8'(numval("34", 10)));
		dchk(8, 8'(numval("5F", 16)));
		bus(1'b1, `REG_LINE, 32'h6000);
		bus(1'b1, `LIST_BASE + 12'h4, act(OP_RAW, 2'h0, 1'b0, 8'h1, 8'h0, 8'h0));
		bus(1'b1, `LIST_BASE + 12'h8, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h3);
		serial_sender_i.send(8'h35, 1'b1, 1'b0);
		serial_sender_i.send(8'h21, 1'b1, 1'b1);
		wait_idle();
		check(rd[7:0], 8'h04);
		dchk(0, 8'h35);
		dchk(1, v[7:0]);
		bus(1'b1, `REG_LINE, 32'h0);
		inv <= 1'b0;
		repeat (12 * BIT_CYC) @(posedge clk_in);
		bus(1'b1, `REG_TMO, 32'd150);
		bus(1'b1, `LIST_BASE, act(OP_NUM, `BASE_DEC, 1'b0, 8'h0, 8'h0, 8'h0));
		bus(1'b1, `LIST_BASE + 12'h4, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h5);
		send_str("ab");
		bus(1'b1, `REG_LINE, 32'h4000);
		bus(1'b0, `REG_STATUS, 32'h0);
		check(rd[3:0], 4'h1);
		wait_idle();
		check(rd[15:0], 16'h6208);
		rdchk(`REG_LINE, 32'h0, 1'b0);
		rdchk(`REG_CTRL, 32'h4, 1'b0);
		complete_run();
	end
endmodule : tb_rx_filter
